/* File: bench/awcdp_top_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "awcdp_map.svh"
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin n_errors++; $display("MISMATCH %s exp %h seen %h", nm, e, s); end end
module awcdp_top_tb_top;
  typedef struct {string nm; logic [31:0] ex; logic [31:0] mk; logic [1:0] rs;} awcdp_note_type;
  // Bus master side
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata;
  logic awvalid, wvalid, arvalid;
  logic bready = 1'b1;
  logic rready = 1'b1;
  wire awready, wready, bvalid, arready, rvalid, dataOutFull;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] dataOut, addrOut, ioPortOut;
  // Expectation queues and model state
  int seed = 7;
  int n_errors = 0;
  int compares = 0;
  int i;
  awcdp_note_type rdQ[$];
  awcdp_note_type nt;
  logic [1:0] bQ[$];
  logic [1:0] br;
  logic [15:0] regs [0:31];
  logic [15:0] cV, inL, adrI, datI, swV;
  logic [15:0] dout = 16'h0;
  logic [15:0] aout = 16'h0;
  logic [15:0] iop = 16'h0;
  logic [7:0] fl = 8'h00;
  logic [7:0] rej = 8'h00;
  logic [15:0] kT [0:2] = '{16'hFFFF, 16'h7FFF, 16'hFFFF};
  logic [15:0] sT [0:2] = '{16'h0000, 16'h0001, 16'hFFFF};
  logic cT [0:2] = '{1'b1, 1'b0, 1'b1};
  logic [5:0] srcT [0:5] = '{6'h27, 6'h28, 6'h29, 6'h2A, 6'h2B, 6'h07};
  logic [5:0] dT [0:5] = '{6'h22, 6'h23, 6'h24, 6'h25, 6'h21, 6'h26};
  logic [3:0] sqT [0:2] = '{4'h1, 4'h8, 4'hF};

  // Byte strobes stay whole: the bench writes every register as a full word
  awcdp_top uut (
    .clock(clock),
    .rst_n(rst_n),
    .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid),
    .s_axi_awready(awready),
    .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid),
    .s_axi_wready(wready),
    .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid),
    .s_axi_bready(bready),
    .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid),
    .s_axi_arready(arready),
    .s_axi_rdata(rdata),
    .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid),
    .s_axi_rready(rready),
    .dataOut(dataOut),
    .dataOutFull(dataOutFull),
    .addrOut(addrOut),
    .ioPortOut(ioPortOut)
  );

  // Clock at 10 MHz
  always #50 clock = ~clock;

  // Watcher: each answer takes the oldest note off its queue
  always @(posedge clock) begin
    if (rst_n && rvalid && rready) begin
      nt = rdQ.pop_front();
      `CHK(nt.nm, nt.ex & nt.mk, rdata & nt.mk)
      `CHK(nt.nm, {30'h0, nt.rs}, {30'h0, rresp})
    end
    if (rst_n && bvalid && bready) begin
      br = bQ.pop_front();
      `CHK("bresp", {30'h0, br}, {30'h0, bresp})
    end
  end

  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // A bus wait that runs out ends the run
  task automatic tmo(input int n);
    if (n >= 60) begin
      n_errors++;
      $display("MISMATCH bus wait exp answer seen none");
      conclude();
    end
  endtask

  // Write: address and data offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
    int n;
    bQ.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 60);
    tmo(n);
  endtask

  task automatic axr(input logic [7:0] a, input string nm, input logic [31:0] e, input logic [1:0] r = 2'b00);
    int n;
    rdQ.push_back('{nm, e, 32'hFFFFFFFF, r});
    araddr <= a;
    arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 60);
    tmo(n);
  endtask

  function automatic logic [15:0] val(input logic [5:0] c);
    case (c)
      `AWCDP_OP_CONST: return cV;
      `AWCDP_OP_INLATCH: return inL;
      `AWCDP_OP_ADRIN: return adrI;
      `AWCDP_OP_SWPAT: return swV;
      `AWCDP_OP_DATIN: return datI;
      `AWCDP_OP_DATOUT: return dout;
      default: return regs[c[4:0]];
    endcase
  endfunction

  // Outside sources: the switch pattern, the constant and the carry as given; the other three random
  task automatic setIn(input logic [15:0] k, input logic [15:0] sw, input logic c);
    cV = k;
    swV = sw;
    inL = 16'($random(seed));
    adrI = 16'($random(seed));
    datI = 16'($random(seed));
    axw(`AWCDP_ADDR_CONST, {16'h0, cV});
    axw(`AWCDP_ADDR_EXTIN, {adrI, inL});
    axw(`AWCDP_ADDR_EXTIN2, {datI, swV});
    axw(`AWCDP_ADDR_FLAGS, {30'h0, c, 1'b0});
    fl[1] = c;
  endtask

  // One instruction: model it, start it, then check every visible effect
  task automatic run(input logic th, input logic [3:0] sq, input logic cf, input logic [5:0] d,
                     input logic [5:0] s1, input logic [5:0] s2);
    logic [15:0] a, b;
    logic [16:0] s;
    logic ok;
    a = th ? val(s1) : val(d);
    b = th ? val(s2) : val(s1);
    s = {1'b0, a} + {1'b0, b} + {16'h0, fl[1]};
    ok = !((sq != 4'h0 && (cf || s1 == `AWCDP_OP_CONST || (th && s2 == `AWCDP_OP_CONST)))
         || (!th && d > 6'h20 && s1 > 6'h20) || d >= `AWCDP_OP_INLATCH);
    axw(`AWCDP_ADDR_INSTR, {th, sq, cf, 2'b00, d, s1, s2, 6'h00});
    axw(`AWCDP_ADDR_EXEC, 32'h1);
    // Start lands on the same edge as the response, results the edge after
    repeat (3) @(posedge clock);
    if (ok) begin
      fl[3:0] = {a[15] == b[15] && s[15] != a[15], s[15], s[16], s[15:0] == 16'h0};
      fl[7] = 1'b0;
      if (d < 6'h20) regs[d[4:0]] = s[15:0];
      if (d == `AWCDP_OP_ACCH) fl[4] = fl[3];
      if (d == `AWCDP_OP_ACCL) fl[4] = s[16];
      if (d == `AWCDP_OP_BLKCNT) fl[5] = fl[0];
      if (d == `AWCDP_OP_DATOUT) fl[6] = 1'b1;
      if (d == `AWCDP_OP_DATOUT) dout = s[15:0];
      if (d == `AWCDP_OP_ADROUT) aout = s[15:0];
      if (d == `AWCDP_OP_IOPORT) iop = s[15:0];
      axr(`AWCDP_ADDR_RESULT, "result", {16'h0, s[15:0]});
    end else begin
      fl[7] = 1'b1;
      rej = rej + 8'h01;
    end
    axr(`AWCDP_ADDR_FLAGS, "flags", {24'h0, fl});
    axr(`AWCDP_ADDR_ERRCNT, "rejects", {24'h0, rej});
    axr(`AWCDP_ADDR_EXEC, "busy", 32'h0);
    if (d < 6'h20) begin
      axw(`AWCDP_ADDR_REGSEL, {26'h0, d});
      axr(`AWCDP_ADDR_REGDATA, "register", {16'h0, regs[d[4:0]]});
    end
    `CHK("dataOut", dout, dataOut)
    `CHK("dataOutFull", fl[6], dataOutFull)
    `CHK("addrOut", aout, addrOut)
    `CHK("ioPortOut", iop, ioPortOut)
  endtask

  // Main sequence
  initial begin
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    axr(`AWCDP_ADDR_FLAGS, "flags", 32'h0);
    axr(8'h3C, "unmapped", 32'h0, 2'b10);
    axw(8'h40, 32'h1, 2'b10);
    // Registers loaded with boundary sums first, carry in both states
    for (i = 0; i < 8; i++) begin
      setIn(i < 3 ? kT[i] : 16'($random(seed)), i < 3 ? sT[i] : 16'($random(seed)), i < 3 ? cT[i] : 1'($random(seed)));
      run(1'b1, 4'h0, 1'b0, 6'(i), `AWCDP_OP_CONST, `AWCDP_OP_SWPAT);
    end
    // Accumulate into one register from each outside source and from a general register
    for (i = 0; i < 6; i++) begin
      setIn(16'($random(seed)), 16'($random(seed)), 1'($random(seed)));
      run(1'b0, 4'h0, 1'b0, 6'h00, srcT[i], 6'h00);
    end
    run(1'b0, 4'h0, 1'b0, 6'h03, 6'h03, 6'h00);
    run(1'b1, 4'h0, 1'b0, 6'h04, 6'h04, `AWCDP_OP_CONST);
    // Special destinations; the counter is driven to exactly zero
    for (i = 0; i < 6; i++) begin
      setIn(dT[i] == `AWCDP_OP_BLKCNT ? 16'h0 - regs[2] : 16'($random(seed)), 16'h0, 1'b0);
      run(1'b1, 4'h0, 1'b0, dT[i], 6'h02, `AWCDP_OP_CONST);
    end
    run(1'b0, 4'h0, 1'b0, `AWCDP_OP_DATOUT, 6'h05, 6'h00);
    axw(`AWCDP_ADDR_FLAGS, 32'h40);
    fl[6] = 1'b0;
    fl[1] = 1'b0;
    repeat (2) @(posedge clock);
    `CHK("dataOutFull", 1'b0, dataOutFull)
    // Refused combinations; after the three branch-with-constant cases, each beside a legal neighbour
    for (i = 0; i < 3; i++) begin
      run(1'b0, sqT[i], 1'b0, 6'h06, `AWCDP_OP_CONST, 6'h00);
    end
    run(1'b1, 4'h2, 1'b0, 6'h06, 6'h01, `AWCDP_OP_CONST);
    run(1'b1, 4'h3, 1'b0, 6'h07, 6'h01, 6'h02);
    run(1'b1, 4'h5, 1'b1, 6'h06, 6'h01, 6'h02);
    run(1'b1, 4'h0, 1'b1, 6'h06, 6'h01, `AWCDP_OP_CONST);
    run(1'b0, 4'h0, 1'b0, `AWCDP_OP_DATOUT, `AWCDP_OP_INLATCH, 6'h00);
    run(1'b1, 4'h0, 1'b0, `AWCDP_OP_INLATCH, 6'h01, 6'h02);
    run(1'b0, 4'h0, 1'b0, 6'h01, 6'h02, 6'h00);
    conclude();
  end
endmodule
`default_nettype wire

/* File: src/awcdp_adder.sv */
`timescale 1ns/10ps
`default_nettype none
module awcdp_adder (
  // Operands
  input wire logic [15:0] opA,
  input wire logic [15:0] opB,
  input wire logic carryIn,
  // Result
  output awcdp_pkg::awcdp_sum_type result
);
  logic [16:0] wide;
  // 17-bit sum keeps the carry out of bit 15
  assign wide = {1'b0, opA} + {1'b0, opB} + {16'h0000, carryIn};
  assign result.sum = wide[15:0];
  assign result.flags.carry = wide[16];
  assign result.flags.zero = (wide[15:0] == 16'h0000);
  assign result.flags.sign = wide[15];
  // Signed overflow: like-signed operands, result sign differs
  assign result.flags.overflow = (opA[15] == opB[15]) && (wide[15] != opA[15]);
endmodule
`default_nettype wire

/* File: src/awcdp_map.svh */
`ifndef AWCDP_MAP_SVH
`define AWCDP_MAP_SVH
// Register map (byte addresses, AXI4-Lite)
`define AWCDP_ADDR_INSTR 8'h00
`define AWCDP_ADDR_CONST 8'h04
`define AWCDP_ADDR_EXEC 8'h08
`define AWCDP_ADDR_FLAGS 8'h0C
`define AWCDP_ADDR_RESULT 8'h10
`define AWCDP_ADDR_REGSEL 8'h14
`define AWCDP_ADDR_REGDATA 8'h18
`define AWCDP_ADDR_EXTIN 8'h1C
`define AWCDP_ADDR_EXTIN2 8'h20
`define AWCDP_ADDR_ERRCNT 8'h24
// Instruction word fields
`define AWCDP_F_THREE 31
`define AWCDP_F_SEQ_HI 30
`define AWCDP_F_SEQ_LO 27
`define AWCDP_F_CFG 26
`define AWCDP_F_DST_HI 23
`define AWCDP_F_DST_LO 18
`define AWCDP_F_S1_HI 17
`define AWCDP_F_S1_LO 12
`define AWCDP_F_S2_HI 11
`define AWCDP_F_S2_LO 6
// Operand codes: 0..31 general registers
`define AWCDP_OP_SHIFTQ 6'h20
`define AWCDP_OP_ADROUT 6'h21
`define AWCDP_OP_ACCH 6'h22
`define AWCDP_OP_ACCL 6'h23
`define AWCDP_OP_BLKCNT 6'h24
`define AWCDP_OP_DATOUT 6'h25
`define AWCDP_OP_IOPORT 6'h26
`define AWCDP_OP_INLATCH 6'h27
`define AWCDP_OP_ADRIN 6'h28
`define AWCDP_OP_SWPAT 6'h29
`define AWCDP_OP_CONST 6'h2A
`define AWCDP_OP_DATIN 6'h2B
`define AWCDP_SEQ_CONT 4'h0
// Flag bit positions in FLAGS register
`define AWCDP_FL_ZERO 0
`define AWCDP_FL_CARRY 1
`define AWCDP_FL_SIGN 2
`define AWCDP_FL_OVF 3
`define AWCDP_FL_ACCOVF 4
`define AWCDP_FL_BCZERO 5
`define AWCDP_FL_DORFULL 6
`define AWCDP_FL_REJECT 7
`endif

/* File: src/awcdp_pkg.sv */
package awcdp_pkg;
  // Arithmetic flag group
  typedef struct packed {
    logic overflow;
    logic sign;
    logic carry;
    logic zero;
  } awcdp_flags_type;
  // Adder result bundle
  typedef struct packed {
    logic [15:0] sum;
    awcdp_flags_type flags;
  } awcdp_sum_type;
  typedef enum logic [1:0] {AWCDP_IDLE, AWCDP_EXEC, AWCDP_DONE} awcdp_state_type;
endpackage

/* File: src/awcdp_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "awcdp_map.svh"
module awcdp_top (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Datapath destination outputs
  output logic [15:0] dataOut,
  output logic dataOutFull,
  output logic [15:0] addrOut,
  output logic [15:0] ioPortOut
);
  localparam logic [1:0] RESP_OK = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;

  // Register store
  logic [15:0] genReg [0:31];
  logic [15:0] shiftQ, accHigh, accLow, blkCnt;
  logic [15:0] inLatch, addrIn, swPattern, dataIn, immConst;
  logic [31:0] instrWord;
  logic [4:0] regSel;
  logic [15:0] lastResult;
  logic [7:0] rejectCount;
  awcdp_pkg::awcdp_flags_type arithFlags;
  logic accOverflow, blkCntZero, rejected;
  awcdp_pkg::awcdp_state_type state;

  // Operand read mux, shared for both sources and destination
  function automatic logic [15:0] readOperand(input logic [5:0] code);
    logic [15:0] val;
    val = 16'h0000;
    case (code)
      `AWCDP_OP_SHIFTQ: val = shiftQ;
      `AWCDP_OP_ADROUT: val = addrOut;
      `AWCDP_OP_ACCH: val = accHigh;
      `AWCDP_OP_ACCL: val = accLow;
      `AWCDP_OP_BLKCNT: val = blkCnt;
      `AWCDP_OP_DATOUT: val = dataOut;
      `AWCDP_OP_IOPORT: val = ioPortOut;
      `AWCDP_OP_INLATCH: val = inLatch;
      `AWCDP_OP_ADRIN: val = addrIn;
      `AWCDP_OP_SWPAT: val = swPattern;
      `AWCDP_OP_CONST: val = immConst;
      `AWCDP_OP_DATIN: val = dataIn;
      default: val = (code[5] == 1'b0) ? genReg[code[4:0]] : 16'h0000;
    endcase
    return val;
  endfunction

  // Internal register or shift register test
  function automatic logic isInternal(input logic [5:0] code);
    return (code[5] == 1'b0) || (code == `AWCDP_OP_SHIFTQ);
  endfunction

  // Codes legal as destination (sources-only codes excluded)
  function automatic logic isWritable(input logic [5:0] code);
    return (code[5] == 1'b0) || (code <= `AWCDP_OP_IOPORT);
  endfunction

  // Instruction decode
  wire threeForm = instrWord[`AWCDP_F_THREE];
  wire [3:0] seqField = instrWord[`AWCDP_F_SEQ_HI:`AWCDP_F_SEQ_LO];
  wire cfgOp = instrWord[`AWCDP_F_CFG];
  wire [5:0] dstCode = instrWord[`AWCDP_F_DST_HI:`AWCDP_F_DST_LO];
  wire [5:0] src1Code = instrWord[`AWCDP_F_S1_HI:`AWCDP_F_S1_LO];
  wire [5:0] src2Code = instrWord[`AWCDP_F_S2_HI:`AWCDP_F_S2_LO];
  wire [5:0] srcACode = threeForm ? src1Code : dstCode;
  wire [5:0] srcBCode = threeForm ? src2Code : src1Code;
  logic [15:0] opA, opB;
  // A process, not an assign: the mux must follow register contents too
  always_comb begin
    opA = readOperand(srcACode);
    opB = readOperand(srcBCode);
  end
  wire usesConst = (srcACode == `AWCDP_OP_CONST) || (srcBCode == `AWCDP_OP_CONST);
  wire seqViolation = (usesConst || cfgOp) && (seqField != `AWCDP_SEQ_CONT);
  // two-operand form needs an internal register
  wire formViolation = !threeForm && !isInternal(dstCode) && !isInternal(src1Code);
  wire illegal = seqViolation || formViolation || !isWritable(dstCode);

  // 16-bit add with carry in and carry out
  awcdp_pkg::awcdp_sum_type addRes;
  awcdp_adder adder (
    .opA(opA),
    .opB(opB),
    .carryIn(arithFlags.carry),
    .result(addRes)
  );

  // AXI write channel decode
  logic awHeld, wHeld;
  logic [7:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  wire doWrite = awHeld && wHeld && !s_axi_bvalid;
  wire wrInstr = doWrite && (awAddr == `AWCDP_ADDR_INSTR);
  wire wrConst = doWrite && (awAddr == `AWCDP_ADDR_CONST);
  wire wrExec = doWrite && (awAddr == `AWCDP_ADDR_EXEC) && wData[0] && wStrb[0];
  wire wrRegSel = doWrite && (awAddr == `AWCDP_ADDR_REGSEL);
  wire wrRegData = doWrite && (awAddr == `AWCDP_ADDR_REGDATA);
  wire wrExtIn = doWrite && (awAddr == `AWCDP_ADDR_EXTIN);
  wire wrExtIn2 = doWrite && (awAddr == `AWCDP_ADDR_EXTIN2);
  wire wrFlags = doWrite && (awAddr == `AWCDP_ADDR_FLAGS);
  wire wrKnown = wrInstr || wrConst || (doWrite && awAddr == `AWCDP_ADDR_EXEC) || wrRegSel || wrRegData
    || wrExtIn || wrExtIn2 || wrFlags;
  wire [31:0] nextInstr = {wStrb[3] ? wData[31:24] : instrWord[31:24], wStrb[2] ? wData[23:16] : instrWord[23:16],
    wStrb[1] ? wData[15:8] : instrWord[15:8], wStrb[0] ? wData[7:0] : instrWord[7:0]};
  wire [15:0] next_halfConst = {wStrb[1] ? wData[15:8] : immConst[15:8], wStrb[0] ? wData[7:0] : immConst[7:0]};
  wire execNow = (state == awcdp_pkg::AWCDP_EXEC);

  // Write address and data capture, either order
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 8'h00;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end
    end
  end

  // Ready and response handshakes
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      s_axi_awready <= !awHeld && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !wHeld && !(s_axi_wvalid && s_axi_wready);
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrKnown ? RESP_OK : RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control state: one cycle execute after an exec write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= awcdp_pkg::AWCDP_IDLE;
    end else begin
      case (state)
        awcdp_pkg::AWCDP_IDLE: state <= wrExec ? awcdp_pkg::AWCDP_EXEC : awcdp_pkg::AWCDP_IDLE;
        awcdp_pkg::AWCDP_EXEC: state <= awcdp_pkg::AWCDP_DONE;
        awcdp_pkg::AWCDP_DONE: state <= awcdp_pkg::AWCDP_IDLE;
        default: state <= awcdp_pkg::AWCDP_IDLE;
      endcase
    end
  end

  // Software-loaded words and source inputs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      instrWord <= 32'h0000_0000;
      immConst <= 16'h0000;
      regSel <= 5'h00;
      inLatch <= 16'h0000;
      addrIn <= 16'h0000;
      swPattern <= 16'h0000;
      dataIn <= 16'h0000;
    end else begin
      if (wrInstr) instrWord <= nextInstr;
      if (wrConst) immConst <= next_halfConst;
      if (wrRegSel) regSel <= wData[4:0];
      if (wrExtIn) begin
        inLatch <= wData[15:0];
        addrIn <= wData[31:16];
      end
      if (wrExtIn2) begin
        swPattern <= wData[15:0];
        dataIn <= wData[31:16];
      end
    end
  end

  // General registers: software load or datapath write
  always_ff @(posedge clock) begin
    if (execNow && !illegal && dstCode[5] == 1'b0) begin
      genReg[dstCode[4:0]] <= addRes.sum;
    end else if (wrRegData) begin
      genReg[regSel] <= wData[15:0];
    end
  end

  // result and flags commit in the single execute cycle; a FLAGS write outside it loads carry from bit 1 and clears the output flag only if bit 6 is set
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      shiftQ <= 16'h0000;
      addrOut <= 16'h0000;
      accHigh <= 16'h0000;
      accLow <= 16'h0000;
      blkCnt <= 16'h0000;
      dataOut <= 16'h0000;
      ioPortOut <= 16'h0000;
      arithFlags <= 4'h0;
      accOverflow <= 1'b0;
      blkCntZero <= 1'b0;
      dataOutFull <= 1'b0;
      rejected <= 1'b0;
      lastResult <= 16'h0000;
      rejectCount <= 8'h00;
    end else if (execNow) begin
      rejected <= illegal;
      if (illegal) begin
        rejectCount <= rejectCount + 8'h01;
      end else begin
        lastResult <= addRes.sum;
        arithFlags <= addRes.flags;
        case (dstCode)
          `AWCDP_OP_SHIFTQ: shiftQ <= addRes.sum;
          `AWCDP_OP_ADROUT: addrOut <= addRes.sum;
          `AWCDP_OP_ACCH: begin
            accHigh <= addRes.sum;
            accOverflow <= addRes.flags.overflow;
          end
          `AWCDP_OP_ACCL: begin
            accLow <= addRes.sum;
            accOverflow <= addRes.flags.carry;
          end
          `AWCDP_OP_BLKCNT: begin
            blkCnt <= addRes.sum;
            blkCntZero <= addRes.flags.zero;
          end
          // data output register and its flag
          `AWCDP_OP_DATOUT: begin
            dataOut <= addRes.sum;
            dataOutFull <= 1'b1;
          end
          `AWCDP_OP_IOPORT: ioPortOut <= addRes.sum;
          default: ;
        endcase
      end
    end else if (wrFlags) begin
      // Software may reseed the carry and clear the output flag
      arithFlags.carry <= wData[`AWCDP_FL_CARRY];
      if (wData[`AWCDP_FL_DORFULL]) dataOutFull <= 1'b0;
    end
  end

  // Read data selection
  wire [31:0] flagWord = {24'h000000, rejected, dataOutFull, blkCntZero, accOverflow,
    arithFlags.overflow, arithFlags.sign, arithFlags.carry, arithFlags.zero};
  logic [31:0] rdSel;
  logic rdHit;
  always_comb begin
    rdHit = 1'b1;
    case (s_axi_araddr)
      `AWCDP_ADDR_INSTR: rdSel = instrWord;
      `AWCDP_ADDR_CONST: rdSel = {16'h0000, immConst};
      `AWCDP_ADDR_EXEC: rdSel = {31'h0000_0000, state != awcdp_pkg::AWCDP_IDLE};
      `AWCDP_ADDR_FLAGS: rdSel = flagWord;
      `AWCDP_ADDR_RESULT: rdSel = {16'h0000, lastResult};
      `AWCDP_ADDR_REGSEL: rdSel = {27'h0000000, regSel};
      `AWCDP_ADDR_REGDATA: rdSel = {16'h0000, genReg[regSel]};
      `AWCDP_ADDR_EXTIN: rdSel = {addrIn, inLatch};
      `AWCDP_ADDR_EXTIN2: rdSel = {dataIn, swPattern};
      `AWCDP_ADDR_ERRCNT: rdSel = {24'h000000, rejectCount};
      default: begin
        rdSel = 32'h0000_0000;
        rdHit = 1'b0;
      end
    endcase
  end

  // Read channel: address taken, data one cycle later
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdSel;
        s_axi_rresp <= rdHit ? RESP_OK : RESP_ERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks
  sequence execIllegal;
    execNow && illegal;
  endsequence
  AST_CONST_CONT: assert property (@(posedge clock) disable iff (!rst_n)
    execNow && usesConst && seqField != `AWCDP_SEQ_CONT |=> rejected) else $error("constant with branch not rejected");
  AST_CFG_CONT: assert property (@(posedge clock) disable iff (!rst_n)
    execNow && cfgOp && seqField != `AWCDP_SEQ_CONT |=> rejected) else $error("config with branch not rejected");
  AST_FORM_CHECK: assert property (@(posedge clock) disable iff (!rst_n)
    execIllegal |=> $stable(lastResult) && rejectCount == $past(rejectCount) + 8'h01) else $error("illegal op committed");
  AST_SUM: assert property (@(posedge clock) disable iff (!rst_n)
    execNow && !illegal |=> lastResult == 16'($past(opA) + $past(opB) + 16'($past(arithFlags.carry))))
    else $error("sum wrong");
  AST_CARRY: assert property (@(posedge clock) disable iff (!rst_n)
    execNow && !illegal |=> arithFlags.carry == (({1'b0, $past(opA)} + {1'b0, $past(opB)}
    + 17'($past(arithFlags.carry))) > 17'h0FFFF)) else $error("carry wrong");
  AST_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
    execNow && !illegal |=> arithFlags.zero == (lastResult == 16'h0000) && arithFlags.sign == lastResult[15])
    else $error("zero or sign wrong");
  AST_DOR_FLAG: assert property (@(posedge clock) disable iff (!rst_n)
    execNow && !illegal && dstCode == `AWCDP_OP_DATOUT |=> dataOutFull && dataOut == lastResult)
    else $error("data out flag missing");
  AST_BCZ: assert property (@(posedge clock) disable iff (!rst_n)
    execNow && !illegal && dstCode == `AWCDP_OP_BLKCNT |=> blkCntZero == (blkCnt == 16'h0000))
    else $error("block counter zero wrong");
  AST_SRC_FLAGS: assert property (@(posedge clock) disable iff (!rst_n)
    execNow && !illegal && dstCode[5] == 1'b0 |=> $stable(accOverflow) && $stable(blkCntZero))
    else $error("special flag touched");
  AST_ONE_CYCLE: assert property (@(posedge clock) disable iff (!rst_n)
    wrExec && state == awcdp_pkg::AWCDP_IDLE |=> execNow ##1 !execNow) else $error("execute not single cycle");
endmodule
`default_nettype wire
